/* hw/cpm_pkg.sv */
// Constants, register map and types for the charge pump gain controller.
// Assumes a single 250 MHz reference clock and comparator inputs already synchronous to it.
package cpm_pkg;

   // Clock and printed times
   localparam real CLK_PERIOD_NS = 4.0;
   localparam real GAIN_CHANGE_TIME_US = 400.0;
   localparam real POWER_OFF_DELAY_MS = 0.9;
   localparam real POWER_OFF_MAX_MS = 1.5;
   localparam real SETTLE_1X_US = 40.0;
   localparam real SETTLE_133_US = 400.0;
   localparam real DIAG_TIME_US = 10.0;

   // Cycle counts; every delay rounds down
   localparam int GAIN_CHANGE_CYC = int'($floor(GAIN_CHANGE_TIME_US * 1000.0 / CLK_PERIOD_NS));
   localparam int POWER_OFF_CYC = int'($floor(POWER_OFF_DELAY_MS * 1000000.0 / CLK_PERIOD_NS));
   localparam int POWER_OFF_MAX_CYC = int'($floor(POWER_OFF_MAX_MS * 1000000.0 / CLK_PERIOD_NS));
   localparam int SETTLE_1X_CYC = int'($floor(SETTLE_1X_US * 1000.0 / CLK_PERIOD_NS));
   localparam int SETTLE_133_CYC = int'($floor(SETTLE_133_US * 1000.0 / CLK_PERIOD_NS));
   localparam int DIAG_CYC = int'($floor(DIAG_TIME_US * 1000.0 / CLK_PERIOD_NS));
   localparam int TMR_W = 18;

   // Register map, byte addresses
   localparam int ADR_W = 8;
   localparam logic [ADR_W-1:0] REG_CTRL = 8'h00;
   localparam logic [ADR_W-1:0] REG_STATUS = 8'h04;
   localparam logic [ADR_W-1:0] REG_IRQ_STATUS = 8'h08;
   localparam logic [ADR_W-1:0] REG_IRQ_MASK = 8'h0C;

   // Control fields and reset values
   localparam int NCH = 4;
   localparam int CTRL_RESTART_BIT = 4;
   localparam logic [NCH-1:0] CTRL_ALLOW_RESET = 4'hF;

   // Event bits
   localparam int IRQ_W = 6;
   localparam int EV_GAIN = 0;
   localparam int EV_OFF = 1;
   localparam int EV_OPEN = 2;
   localparam int EV_OVP = 3;
   localparam int EV_HOT = 4;
   localparam int EV_LOW = 5;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 6'h00;

   typedef enum logic [1:0] {CPM_G1X, CPM_G133, CPM_G15, CPM_G2X} cpm_gain_e;
   typedef enum logic [1:0] {CPM_OFF, CPM_START, CPM_RUN, CPM_DIAG} cpm_state_e;

endpackage

/* hw/cpm_timer.sv */
// Saturating cycle timer used for every delay of the controller.
// Assumes restart has priority over run; limit may change while counting, and a count already past it runs on and wraps.
`timescale 1ns/100ps
module cpm_timer
   import cpm_pkg::*;
#(
   parameter int W = TMR_W
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Control
   input wire logic restart,
   input wire logic run,
   input wire logic [W-1:0] limit,
   // Result
   output logic done
);

   logic [W-1:0] cnt;

   // Counts up and parks at the limit so done stays high while run holds, until restarted
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= '0;
      end else if (restart) begin
         cnt <= '0;
      end else if (run && cnt != limit) begin
         cnt <= cnt + 1'b1;
      end
   end

   assign done = run && (cnt == limit);

endmodule

/* hw/cpm_events.sv */
// Sticky event flags with read-to-clear, a mask and one level interrupt.
// Assumes clr_rd is a one-cycle pulse at the bus edge that returns the status word.
`timescale 1ns/100ps
module cpm_events
   import cpm_pkg::*;
#(
   parameter int N = IRQ_W
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Events and software access
   input wire logic [N-1:0] set,
   input wire logic clr_rd,
   input wire logic mask_we,
   input wire logic [N-1:0] mask_din,
   // State
   output logic [N-1:0] status,
   output logic [N-1:0] mask,
   output logic irq
);

   // A set in the clearing cycle survives, so no event is lost
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status <= '0;
      end else begin
         status <= set | (clr_rd ? '0 : status);
      end
   end

   // Mask register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mask <= IRQ_MASK_RESET;
      end else if (mask_we) begin
         mask <= mask_din;
      end
   end

   // Registered interrupt level, built from the next status and next mask so it tracks both registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |((set | (clr_rd ? '0 : status)) & (mask_we ? mask_din : mask));
      end
   end

endmodule

/* hw/cpm_ctrl.sv */
// Charge pump gain controller: gain stepping, enable/dimming gating, shutdown
// timing, diagnostics and fault handling, with a classic Wishbone register slave.
// Assumes all sense inputs and EN are synchronous to REF_CLK.
`timescale 1ns/100ps
module cpm_ctrl
   import cpm_pkg::*;
#(
   parameter logic [TMR_W-1:0] GAIN_CHANGE_CYCLES = TMR_W'(GAIN_CHANGE_CYC),
   parameter logic [TMR_W-1:0] POWER_OFF_CYCLES = TMR_W'(POWER_OFF_CYC),
   parameter logic [TMR_W-1:0] SETTLE_1X_CYCLES = TMR_W'(SETTLE_1X_CYC),
   parameter logic [TMR_W-1:0] SETTLE_133_CYCLES = TMR_W'(SETTLE_133_CYC)
) (
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic RST_N,
   // Wishbone slave
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [ADR_W-1:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   // Host enable and dimming pin
   input wire logic EN,
   // Comparator results
   input wire logic [NCH-1:0] HEADROOM_OK,
   input wire logic [NCH-1:0] SINK_TIED_TO_PUMP_OUTPUT,
   input wire logic [NCH-1:0] OPEN_LED_SENSE,
   input wire logic SUPPLY_INPUT_SUFFICIENT,
   input wire logic PUMP_OUTPUT_OVER,
   input wire logic SUPPLY_LOW_LOCKOUT,
   input wire logic DIE_OVER_TEMP,
   input wire logic DIE_TEMP_RECOVERED,
   // Power stage and sink controls, and the interrupt
   output logic [1:0] PUMP_GAIN,
   output logic PUMP_RUN,
   output logic [NCH-1:0] CATHODE_SINK_ON,
   output logic CATHODE_SINK_HIZ,
   output logic CURRENT_SET_RESISTOR_PIN_DRIVE,
   output logic IRQ
);

   cpm_state_e state;
   cpm_state_e next_state;
   cpm_gain_e gain;
   logic en_q;
   logic hot;
   logic thermal_off;
   logic [NCH-1:0] ignored;
   logic [NCH-1:0] allow;
   logic restart_req;
   logic [NCH-1:0] active;
   logic running;
   logic reg_fail;
   logic step_now;
   logic back_to_1x;
   logic gain_reset;
   logic open_seen;
   logic wake;
   logic gain_done;
   logic settle_done;
   logic off_done;
   logic diag_done;
   logic [IRQ_W-1:0] ev_set;
   logic [IRQ_W-1:0] ev_status;
   logic [IRQ_W-1:0] ev_mask;
   logic bus_req;
   logic rd_irq;
   logic mask_we;

   // Channel bookkeeping and derived conditions
   assign active = allow & ~SINK_TIED_TO_PUMP_OUTPUT & ~ignored;
   assign running = (state == CPM_START) || (state == CPM_RUN);
   assign reg_fail = EN && |(active & ~HEADROOM_OK);
   assign step_now = running && gain_done && (gain != CPM_G2X);
   assign back_to_1x = running && (gain != CPM_G1X) && (SUPPLY_INPUT_SUFFICIENT || active == '0);
   assign gain_reset = (state == CPM_OFF) || (PUMP_OUTPUT_OVER && state != CPM_OFF) || restart_req
      || diag_done;
   assign open_seen = EN && (state == CPM_RUN) && |(OPEN_LED_SENSE & active);
   assign wake = EN && !SUPPLY_LOW_LOCKOUT && !hot && (!en_q || thermal_off);

   // Gain step timer runs only while some active channel is out of regulation
   cpm_timer #(.W(TMR_W)) u_gain_tmr (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .restart(!reg_fail || step_now || gain_reset || back_to_1x),
      .run(running && reg_fail),
      .limit(GAIN_CHANGE_CYCLES),
      .done(gain_done)
   );

   // Soft-start settling; the limit lengthens when the gain leaves unity during start, and the count is not restarted
   cpm_timer #(.W(TMR_W)) u_settle_tmr (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .restart(state != CPM_START),
      .run(state == CPM_START),
      .limit(gain == CPM_G1X ? SETTLE_1X_CYCLES : SETTLE_133_CYCLES),
      .done(settle_done)
   );

   // Power-off delay measured from the enable falling edge
   cpm_timer #(.W(TMR_W)) u_off_tmr (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .restart(EN),
      .run(!EN && state != CPM_OFF),
      .limit(POWER_OFF_CYCLES),
      .done(off_done)
   );

   // Diagnostic window after an open LED is seen
   cpm_timer #(.W(TMR_W)) u_diag_tmr (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .restart(state != CPM_DIAG),
      .run(state == CPM_DIAG),
      .limit(TMR_W'(DIAG_CYC)),
      .done(diag_done)
   );

   // Sequencer; faults take priority over every other transition
   always_comb begin
      next_state = state;
      unique case (state)
         CPM_OFF: begin
            if (wake) begin
               next_state = CPM_START;
            end
         end
         CPM_START: begin
            if (settle_done) begin
               next_state = CPM_RUN;
            end
         end
         CPM_RUN: begin
            if (open_seen) begin
               next_state = CPM_DIAG;
            end
         end
         CPM_DIAG: begin
            if (diag_done) begin
               next_state = CPM_RUN;
            end
         end
      endcase
      if (SUPPLY_LOW_LOCKOUT || hot || DIE_OVER_TEMP || off_done) begin
         next_state = CPM_OFF;
      end
   end

   // State register
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state <= CPM_OFF;
      end else begin
         state <= next_state;
      end
   end

   // Enable history for edge detection
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         en_q <= 1'b0;
      end else begin
         en_q <= EN;
      end
   end

   // Thermal latch gives the hysteresis between trip and recovery
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         hot <= 1'b0;
      end else if (DIE_OVER_TEMP) begin
         hot <= 1'b1;
      end else if (DIE_TEMP_RECOVERED) begin
         hot <= 1'b0;
      end
   end

   // Remembers a thermal trip so cooling resumes without a new enable edge
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         thermal_off <= 1'b0;
      end else if (DIE_OVER_TEMP) begin
         thermal_off <= 1'b1;
      end else if (state != CPM_OFF) begin
         thermal_off <= 1'b0;
      end
   end

   // Gain selection: up one step at a time, down only to unity
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         gain <= CPM_G1X;
      end else if (gain_reset || back_to_1x) begin
         gain <= CPM_G1X;
      end else if (step_now) begin
         gain <= cpm_gain_e'(gain + 2'd1);
      end
   end

   // Channels found open at the end of diagnostics are dropped until shutdown
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ignored <= '0;
      end else if (state == CPM_OFF) begin
         ignored <= '0;
      end else if (diag_done) begin
         ignored <= ignored | (OPEN_LED_SENSE & active);
      end
   end

   // Sink gating follows EN with one register of delay in either direction while the sequencer stays out of OFF
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         CATHODE_SINK_ON <= '0;
      end else if (EN && state != CPM_OFF && next_state != CPM_OFF) begin
         CATHODE_SINK_ON <= active;
      end else begin
         CATHODE_SINK_ON <= '0;
      end
   end

   // Power stage and high-impedance controls
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         PUMP_GAIN <= CPM_G1X;
         PUMP_RUN <= 1'b0;
         CATHODE_SINK_HIZ <= 1'b1;
         CURRENT_SET_RESISTOR_PIN_DRIVE <= 1'b0;
      end else begin
         PUMP_GAIN <= gain;
         PUMP_RUN <= (state != CPM_OFF);
         CATHODE_SINK_HIZ <= (state == CPM_OFF);
         CURRENT_SET_RESISTOR_PIN_DRIVE <= (state != CPM_OFF);
      end
   end

   // Event sources for the interrupt block
   always_comb begin
      ev_set = '0;
      ev_set[EV_GAIN] = step_now || (back_to_1x && !gain_reset);
      ev_set[EV_OFF] = (state != CPM_OFF) && (next_state == CPM_OFF);
      ev_set[EV_OPEN] = open_seen;
      ev_set[EV_OVP] = PUMP_OUTPUT_OVER && state != CPM_OFF;
      ev_set[EV_HOT] = DIE_OVER_TEMP && !hot;
      ev_set[EV_LOW] = SUPPLY_LOW_LOCKOUT && state != CPM_OFF;
   end

   cpm_events #(.N(IRQ_W)) u_events (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .set(ev_set),
      .clr_rd(rd_irq),
      .mask_we(mask_we),
      .mask_din(WB_DAT_I[IRQ_W-1:0]),
      .status(ev_status),
      .mask(ev_mask),
      .irq(IRQ)
   );

   // Bus decode; one wait state, ack drops the cycle after it is given
   assign bus_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
   assign rd_irq = bus_req && !WB_WE_I && (WB_ADR_I == REG_IRQ_STATUS);
   assign mask_we = bus_req && WB_WE_I && WB_SEL_I[0] && (WB_ADR_I == REG_IRQ_MASK);

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         WB_ACK_O <= 1'b0;
      end else begin
         WB_ACK_O <= bus_req;
      end
   end

   // Control register: channel allow mask and a self-clearing restart
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         allow <= CTRL_ALLOW_RESET;
         restart_req <= 1'b0;
      end else begin
         restart_req <= 1'b0;
         if (bus_req && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == REG_CTRL) begin
            allow <= WB_DAT_I[NCH-1:0];
            restart_req <= WB_DAT_I[CTRL_RESTART_BIT];
         end
      end
   end

   // Read data is captured at the edge that raises ack; unmapped reads give zero
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         WB_DAT_O <= '0;
      end else if (bus_req && !WB_WE_I) begin
         unique case (WB_ADR_I)
            REG_CTRL: WB_DAT_O <= {28'h000_0000, allow};
            REG_STATUS: WB_DAT_O <= {18'h0_0000, hot, SUPPLY_LOW_LOCKOUT, ignored, active, state, gain};
            REG_IRQ_STATUS: WB_DAT_O <= {26'h000_0000, ev_status};
            REG_IRQ_MASK: WB_DAT_O <= {26'h000_0000, ev_mask};
            default: WB_DAT_O <= '0;
         endcase
      end
   end

   // Checks
   chk_wake_unity: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (state == CPM_OFF ##1 state == CPM_START) |-> gain == CPM_G1X)
      else $error("wake did not start at unity gain");

   chk_step_up: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (step_now && gain == CPM_G1X && !gain_reset && !back_to_1x) |=> gain == CPM_G133)
      else $error("gain did not step to 1.33 after the delay");

   chk_step_chain: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (gain != $past(gain) && gain != CPM_G1X) |-> gain == cpm_gain_e'($past(gain) + 2'd1))
      else $error("gain rose by other than one step");

   chk_down_unity: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (gain < $past(gain)) |-> gain == CPM_G1X)
      else $error("gain stepped down to an intermediate setting");

   chk_sink_off_en: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      !EN |=> CATHODE_SINK_ON == '0)
      else $error("sinks still on after enable low");

   chk_off_cause: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (state != CPM_OFF ##1 state == CPM_OFF) |-> $past(off_done || SUPPLY_LOW_LOCKOUT || hot || DIE_OVER_TEMP))
      else $error("shutdown entered without cause");

   chk_supply_low_lockout_off: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      SUPPLY_LOW_LOCKOUT |=> state == CPM_OFF ##1 CATHODE_SINK_HIZ)
      else $error("under-voltage did not force shutdown");

   chk_hiz_off: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      state == CPM_OFF |=> CATHODE_SINK_HIZ && !CURRENT_SET_RESISTOR_PIN_DRIVE && CATHODE_SINK_ON == '0)
      else $error("outputs not high impedance in shutdown");

   chk_tied_excl: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      SINK_TIED_TO_PUMP_OUTPUT != '0 |=> (CATHODE_SINK_ON & $past(SINK_TIED_TO_PUMP_OUTPUT)) == '0)
      else $error("tied channel was driven");

   chk_all_open: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (running && active == '0) |=> gain == CPM_G1X)
      else $error("no active channel but gain above unity");

   chk_ovp_reset: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (PUMP_OUTPUT_OVER && state != CPM_OFF) |=> gain == CPM_G1X)
      else $error("over-voltage did not reset gain");

   chk_hot_off: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      hot |-> ##1 state == CPM_OFF)
      else $error("running while over temperature");

endmodule

/* tb/cpm_host.sv */
// Host model: drives the enable and dimming pin of the gain controller.
// Assumes the bench calls its task from one process at a time.
`timescale 1ns/100ps
module cpm_host (
   // Clock
   input wire logic clk,
   // Enable pin, low until first driven, then holding its last level while the host is idle
   output logic en
);
   initial en = 1'b0;

   // Pin changes just after an edge and holds for the given cycles
   task automatic drive(input logic lvl, input int n);
      @(posedge clk);
      en <= lvl;
      repeat (n) @(posedge clk);
   endtask

   // Shutdown request: the pin stays low past the power-off delay
   task automatic park(input int n);
      drive(1'b0, n);
   endtask
endmodule

/* tb/charge_pump_mode_controller_tb.sv */
// Self-checking bench for the charge pump gain controller.
// Assumes reduced delay parameters so the whole run stays short.
`timescale 1ns/100ps
module charge_pump_mode_controller_tb;
   import cpm_pkg::*;
   localparam int GC = 20;
   localparam int PO = 50;
   logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, en, irq, run, hiz, drv;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0, hr = 4'hF, tied = 4'h0, open = 4'h0, sink;
   logic [31:0] wdat = 32'h0000_0000, rdat, d;
   logic suf = 1'b0, ovp = 1'b0, uv = 1'b0, hot = 1'b0, cool = 1'b0;
   logic [1:0] gain;
   int mismatches = 0, check_count = 0, ticks = 0;

   always #2 clk = ~clk;

   cpm_host host (.clk(clk), .en(en));

   cpm_ctrl #(.GAIN_CHANGE_CYCLES(18'(GC)), .POWER_OFF_CYCLES(18'(PO)), .SETTLE_1X_CYCLES(18'(10)),
      .SETTLE_133_CYCLES(18'(30))) dut (.REF_CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
      .EN(en), .HEADROOM_OK(hr), .SINK_TIED_TO_PUMP_OUTPUT(tied), .OPEN_LED_SENSE(open),
      .SUPPLY_INPUT_SUFFICIENT(suf), .PUMP_OUTPUT_OVER(ovp), .SUPPLY_LOW_LOCKOUT(uv),
      .DIE_OVER_TEMP(hot), .DIE_TEMP_RECOVERED(cool), .PUMP_GAIN(gain), .PUMP_RUN(run),
      .CATHODE_SINK_ON(sink), .CATHODE_SINK_HIZ(hiz), .CURRENT_SET_RESISTOR_PIN_DRIVE(drv), .IRQ(irq));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Classic single cycle; ack and read data are taken at the same edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] di, output logic [31:0] dq);
      int n;
      n = 0;
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= di; sel <= 4'hF;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 40);
      dq = rdat;
      cyc <= 1'b0; stb <= 1'b0;
      if (n >= 40) chk(32'h0000_0bad, 32'h0000_0000);
      @(posedge clk);
   endtask

   task automatic t_reset;
      chk({hiz, drv, run, gain, sink}, {1'b1, 1'b0, 1'b0, 2'd0, 4'h0});
      wb(1'b0, REG_CTRL, 0, d); chk(d, 32'h0000_000F);
      // Restart bit is self-clearing and not in the read data, so only the allow field reads back
      wb(1'b1, REG_CTRL, 32'h0000_0017, d);
      wb(1'b0, REG_CTRL, 0, d); chk(d, 32'h0000_0007);
      wb(1'b1, REG_CTRL, 32'h0000_000F, d);
      wb(1'b0, REG_IRQ_MASK, 0, d); chk(d, 32'h0000_0000);
      wb(1'b0, 8'h10, 0, d); chk(d, 32'h0000_0000);
   endtask

   task automatic t_wake;
      host.drive(1'b1, 4);
      chk({sink, run, hiz, drv, gain}, {4'hF, 1'b1, 1'b0, 1'b1, 2'd0});
      tick(14);
      wb(1'b0, REG_STATUS, 0, d); chk(d[3:0], {2'd2, 2'd0});
   endtask

   // Each failed-regulation interval raises the gain by one step; steps come GC+1 cycles apart and
   // show on the pin two cycles later, so a lands before the change and a+b after it
   task automatic step(input logic [1:0] g, input int a, input int b);
      tick(a); chk(gain, g - 2'd1);
      tick(b); chk(gain, g);
   endtask

   task automatic t_gain;
      hr <= 4'hE;
      step(2'd1, 15, 10);
      chk(irq, 1'b0);
      wb(1'b1, REG_IRQ_MASK, 32'h0000_0001, d);
      tick(1); chk(irq, 1'b1);
      step(2'd2, 12, 6); step(2'd3, 15, 6);
      tick(GC + 10); chk(gain, 2'd3);
      // Software restart drops the gain and starts the evaluation over
      wb(1'b1, REG_CTRL, 32'h0000_001F, d);
      tick(2); chk(gain, 2'd0);
      step(2'd1, 15, 10);
      ovp <= 1'b1; tick(4); ovp <= 1'b0; chk(gain, 2'd0);
      step(2'd1, 15, 10); step(2'd2, 15, 6);
      suf <= 1'b1;
      repeat (4) begin
         tick(1); chk(gain == 2'd1, 1'b0);
      end
      chk(gain, 2'd0);
      hr <= 4'hF; suf <= 1'b0;
      tick(2);
      wb(1'b0, REG_IRQ_STATUS, 0, d); chk(d[EV_GAIN], 1'b1);
      wb(1'b0, REG_IRQ_STATUS, 0, d); chk(d[EV_GAIN], 1'b0);
      chk(irq, 1'b0);
   endtask

   task automatic t_pwm;
      host.drive(1'b0, 2); chk({sink, run}, {4'h0, 1'b1});
      host.drive(1'b1, 2); chk(sink, 4'hF);
      host.drive(1'b0, PO - 10); chk(run, 1'b1);
      host.park(14); chk({run, hiz, drv, sink}, {1'b0, 1'b1, 1'b0, 4'h0});
   endtask

   task automatic t_fault;
      host.drive(1'b1, 16);
      tied <= 4'h1; tick(3);
      wb(1'b0, REG_STATUS, 0, d); chk(d[7:4], 4'hE);
      chk(sink, 4'hE);
      tied <= 4'h0; open <= 4'h2; tick(2600);
      wb(1'b0, REG_STATUS, 0, d); chk({d[11:8], d[3:0]}, {4'h2, 2'd2, 2'd0});
      // Raise the gain first so settling at unity after all-open diagnostics means something
      hr <= 4'h0; tick(GC + 5); chk(gain, 2'd1);
      open <= 4'hF; tick(2600);
      chk(gain, 2'd0);
      open <= 4'h0; hr <= 4'hF;
      uv <= 1'b1; tick(4); chk({run, hiz}, 2'b01);
      uv <= 1'b0;
      host.drive(1'b0, 2); host.drive(1'b1, 16); chk(run, 1'b1);
      hot <= 1'b1; tick(4); chk(run, 1'b0);
      hot <= 1'b0; cool <= 1'b1; tick(20); chk(run, 1'b1);
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Cuts a hang short well past the expected run length
   always @(posedge clk) begin
      ticks++;
      if (ticks > 20000) begin
         mismatches++;
         results();
      end
   end

   initial begin
      tick(8);
      rst_n <= 1'b1;
      tick(1);
      t_reset(); t_wake(); t_gain(); t_pwm(); t_fault();
      results();
   end
endmodule
